// ===== verilog/dadu_cfg.svh
// constants for the doubleword add and divide unit
// assumes inclusion by bare name from the package and the top module
// What this block does
// - unsigned doubleword add sums full 64 bits, never traps on carry
// - doubleword add and divides trap as reserved in 32-bit user/supervisor
// - signed doubleword divide treats operands as two's complement
// - quotient goes to low product register, remainder to high
// - divides never raise overflow; zero divisor leaves arbitrary values
// - unsigned doubleword divide zero-extends operands before dividing
// - 64-bit word divide uses low 32 bits, sign-extends results
// - product registers poisoned from the second run cycle on, until the fix step writes results
// - 32-bit mode word divide is signed, quotient low, remainder high
`ifndef DADU_CFG_SVH
`define DADU_CFG_SVH
`define DADU_XLEN 64
`define DADU_WLEN 32
`define DADU_STEPS_DWORD 7'h40
`define DADU_STEPS_WORD 7'h20
`define DADU_POISON 64'hDEAD_BEEF_DEAD_BEEF
`endif

// ===== verilog/dadu_pkg.sv
// types for the doubleword add and divide unit
// assumes the cfg header sits on the include path
`default_nettype none
`include "dadu_cfg.svh"
package dadu_pkg;
  typedef enum logic [2:0] {
    DADU_OP_NONE,
    DADU_OP_ADDU,
    DADU_OP_DWORD_SIGNED_DIVIDE,
    DADU_OP_DWORD_UNSIGNED_DIVIDE,
    DADU_OP_DIV
  } dadu_op_t;
  typedef enum logic [1:0] {
    DADU_IDLE,
    DADU_RUN,
    DADU_FIX
  } dadu_state_t;
endpackage : dadu_pkg
`default_nettype wire

// ===== verilog/dadu_div_if.sv
// carrier between the top control and the divider core
// assumes one clock; magnitudes are presented unsigned
`default_nettype none
`include "dadu_cfg.svh"
interface dadu_div_if;
  logic start;
  logic [6:0] steps;
  logic [`DADU_XLEN-1:0] dividend;
  logic [`DADU_XLEN-1:0] divisor;
  logic done;
  logic [`DADU_XLEN-1:0] quot;
  logic [`DADU_XLEN-1:0] rem;
  modport ctl (output start, steps, dividend, divisor, input done, quot, rem);
  modport core (input start, steps, dividend, divisor, output done, quot, rem);
endinterface : dadu_div_if
`default_nettype wire

// ===== verilog/dadu_divcore.sv
// unsigned restoring divider, one quotient bit per cycle
// assumes dividend left-aligned so the top steps bits are the number
`default_nettype none
`include "dadu_cfg.svh"
module dadu_divcore (
  input wire logic clk_i,
  input wire logic rst_b_i,
  dadu_div_if.core bus
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [6:0] cnt;
    logic [`DADU_XLEN-1:0] q;
    logic [`DADU_XLEN-1:0] r;
    logic [`DADU_XLEN-1:0] d;
  } dadu_core_st_t;
  dadu_core_st_t st_reg;
  dadu_core_st_t st_next;
  logic [`DADU_XLEN:0] trial;
  // ===========================================
  // shift-subtract step
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    trial = {st_reg.r, st_reg.q[`DADU_XLEN-1]} - {1'b0, st_reg.d};
    if (bus.start) begin
      st_next.busy = 1'b1;
      st_next.cnt = bus.steps;
      st_next.q = bus.dividend;
      st_next.r = '0;
      st_next.d = bus.divisor;
    end else if (st_reg.busy) begin
      // zero divisor just yields all-ones in the low steps quotient bits, no trap
      if (!trial[`DADU_XLEN]) begin
        st_next.r = trial[`DADU_XLEN-1:0];
        st_next.q = {st_reg.q[`DADU_XLEN-2:0], 1'b1};
      end else begin
        st_next.r = {st_reg.r[`DADU_XLEN-2:0], st_reg.q[`DADU_XLEN-1]};
        st_next.q = {st_reg.q[`DADU_XLEN-2:0], 1'b0};
      end
      st_next.cnt = st_reg.cnt - 7'h01;
      if (st_reg.cnt == 7'h01) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign bus.done = st_reg.done;
  assign bus.quot = st_reg.q;
  assign bus.rem = st_reg.r;
endmodule : dadu_divcore
`default_nettype wire

// ===== verilog/dadu_unit.sv
// top of the doubleword add and divide unit
// assumes decode presents one op per cycle with operands already read
`default_nettype none
`include "dadu_cfg.svh"
module dadu_unit (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic op_valid_i,
  input wire dadu_pkg::dadu_op_t op_i,
  input wire logic mode64_i,
  input wire logic user_or_super_i,
  input wire logic [4:0] dest_field_i,
  input wire logic [`DADU_XLEN-1:0] first_source_i,
  input wire logic [`DADU_XLEN-1:0] second_source_i,
  output logic rd_we_o,
  output logic [4:0] rd_addr_o,
  output logic [`DADU_XLEN-1:0] rd_data_o,
  output logic reserved_trap_o,
  output logic div_busy_o,
  output logic prod_valid_o,
  output logic [`DADU_XLEN-1:0] product_low_reg_o,
  output logic [`DADU_XLEN-1:0] product_high_reg_o
);
  typedef struct packed {
    dadu_pkg::dadu_state_t state;
    logic neg_q;
    logic neg_r;
    logic word_op;
    logic rd_we;
    logic [4:0] rd_addr;
    logic [`DADU_XLEN-1:0] rd_data;
    logic trap;
    logic busy;
    logic prod_valid;
    logic [`DADU_XLEN-1:0] lo;
    logic [`DADU_XLEN-1:0] hi;
  } dadu_top_st_t;
  dadu_top_st_t st_reg;
  dadu_top_st_t st_next;
  logic [1:0] rst_sync_reg;
  logic rst_b;
  logic is_dword;
  logic restricted;
  logic [`DADU_XLEN-1:0] a_mag;
  logic [`DADU_XLEN-1:0] b_mag;
  logic [`DADU_XLEN-1:0] q_fix;
  logic [`DADU_XLEN-1:0] r_fix;
  dadu_div_if dv ();
  // ===========================================
  // reset release
  // assertion is immediate, release waits two edges so every flop leaves
  // reset on one clean edge; kept apart from the state struct because it
  // runs on the raw pin while the struct runs on the released copy
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_reg[1];
  // ===========================================
  // decode checks
  // dword restricted mode
  assign restricted = !mode64_i && user_or_super_i;
  assign is_dword = (op_i == dadu_pkg::DADU_OP_ADDU) || (op_i == dadu_pkg::DADU_OP_DWORD_SIGNED_DIVIDE)
                    || (op_i == dadu_pkg::DADU_OP_DWORD_UNSIGNED_DIVIDE);
  // ===========================================
  // operand magnitudes
  always_comb begin
    a_mag = first_source_i;
    b_mag = second_source_i;
    unique case (op_i)
      dadu_pkg::DADU_OP_DWORD_SIGNED_DIVIDE: begin
        a_mag = first_source_i[`DADU_XLEN-1] ? -first_source_i : first_source_i;
        b_mag = second_source_i[`DADU_XLEN-1] ? -second_source_i : second_source_i;
      end
      dadu_pkg::DADU_OP_DIV: begin
        a_mag = {(first_source_i[`DADU_WLEN-1] ? -first_source_i[`DADU_WLEN-1:0]
                  : first_source_i[`DADU_WLEN-1:0]), 32'h0000_0000};
        b_mag = {32'h0000_0000, (second_source_i[`DADU_WLEN-1]
                  ? -second_source_i[`DADU_WLEN-1:0] : second_source_i[`DADU_WLEN-1:0])};
      end
      default: begin
        a_mag = first_source_i;
        b_mag = second_source_i;
      end
    endcase
  end
  // ===========================================
  // sign correction of core results
  always_comb begin
    q_fix = st_reg.neg_q ? -dv.quot : dv.quot;
    r_fix = st_reg.neg_r ? -dv.rem : dv.rem;
    if (st_reg.word_op) begin
      q_fix = {{32{q_fix[`DADU_WLEN-1]}}, q_fix[`DADU_WLEN-1:0]};
      r_fix = {{32{r_fix[`DADU_WLEN-1]}}, r_fix[`DADU_WLEN-1:0]};
    end
  end
  // ===========================================
  // control
  always_comb begin
    st_next = st_reg;
    st_next.rd_we = 1'b0;
    st_next.trap = 1'b0;
    dv.start = 1'b0;
    dv.steps = `DADU_STEPS_DWORD;
    dv.dividend = a_mag;
    dv.divisor = b_mag;
    if (op_valid_i && (op_i == dadu_pkg::DADU_OP_DIV)) begin
      dv.steps = `DADU_STEPS_WORD;
    end
    unique case (st_reg.state)
      dadu_pkg::DADU_IDLE: begin
        // offers while busy never reach here: refused, not stalled
        if (op_valid_i && op_i != dadu_pkg::DADU_OP_NONE) begin
          if (is_dword && restricted) begin
            // reserved trap
            // trap pulse only, the destination is left untouched
            st_next.trap = 1'b1;
          end else if (op_i == dadu_pkg::DADU_OP_ADDU) begin
            st_next.rd_we = 1'b1;
            st_next.rd_addr = dest_field_i;
            st_next.rd_data = first_source_i + second_source_i;
          end else begin
            dv.start = 1'b1;
            st_next.busy = 1'b1;
            st_next.prod_valid = 1'b0;
            st_next.word_op = (op_i == dadu_pkg::DADU_OP_DIV);
            st_next.neg_q = 1'b0;
            st_next.neg_r = 1'b0;
            if (op_i == dadu_pkg::DADU_OP_DWORD_SIGNED_DIVIDE) begin
              st_next.neg_q = first_source_i[`DADU_XLEN-1] ^ second_source_i[`DADU_XLEN-1];
              st_next.neg_r = first_source_i[`DADU_XLEN-1];
            end else if (op_i == dadu_pkg::DADU_OP_DIV) begin
              st_next.neg_q = first_source_i[`DADU_WLEN-1] ^ second_source_i[`DADU_WLEN-1];
              st_next.neg_r = first_source_i[`DADU_WLEN-1];
            end
            st_next.state = dadu_pkg::DADU_RUN;
          end
        end
      end
      dadu_pkg::DADU_RUN: begin
        // product registers poisoned while running
        // results leave only through the fix step, never half-built
        st_next.lo = `DADU_POISON;
        st_next.hi = `DADU_POISON;
        if (dv.done) begin
          st_next.state = dadu_pkg::DADU_FIX;
        end
      end
      dadu_pkg::DADU_FIX: begin
        st_next.lo = q_fix;
        st_next.hi = r_fix;
        st_next.busy = 1'b0;
        st_next.prod_valid = 1'b1;
        st_next.state = dadu_pkg::DADU_IDLE;
      end
      default: begin
        st_next.state = dadu_pkg::DADU_IDLE;
      end
    endcase
  end
  // ===========================================
  // state registers
  // field by field so the reset values read plainly
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      st_reg.state <= dadu_pkg::DADU_IDLE;
      st_reg.neg_q <= 1'b0;
      st_reg.neg_r <= 1'b0;
      st_reg.word_op <= 1'b0;
      st_reg.rd_we <= 1'b0;
      st_reg.rd_addr <= 5'h00;
      st_reg.rd_data <= 64'h0;
      st_reg.trap <= 1'b0;
      st_reg.busy <= 1'b0;
      st_reg.prod_valid <= 1'b0;
      st_reg.lo <= 64'h0;
      st_reg.hi <= 64'h0;
    end else begin
      st_reg.state <= st_next.state;
      st_reg.neg_q <= st_next.neg_q;
      st_reg.neg_r <= st_next.neg_r;
      st_reg.word_op <= st_next.word_op;
      st_reg.rd_we <= st_next.rd_we;
      st_reg.rd_addr <= st_next.rd_addr;
      st_reg.rd_data <= st_next.rd_data;
      st_reg.trap <= st_next.trap;
      st_reg.busy <= st_next.busy;
      st_reg.prod_valid <= st_next.prod_valid;
      st_reg.lo <= st_next.lo;
      st_reg.hi <= st_next.hi;
    end
  end
  // ===========================================
  // divider core, one quotient bit per edge
  dadu_divcore u_core (
    .clk_i(clk_i),
    .rst_b_i(rst_b),
    .bus(dv)
  );
  // ===========================================
  // outputs, all from flops
  assign rd_we_o = st_reg.rd_we;
  assign rd_addr_o = st_reg.rd_addr;
  assign rd_data_o = st_reg.rd_data;
  assign reserved_trap_o = st_reg.trap;
  assign div_busy_o = st_reg.busy;
  assign prod_valid_o = st_reg.prod_valid;
  assign product_low_reg_o = st_reg.lo;
  assign product_high_reg_o = st_reg.hi;
endmodule : dadu_unit
`default_nettype wire

// ===== bench/dadu_unit_checker.sv
// port assertions for the add and divide unit
// assumes binding onto dadu_unit, one clock domain
`default_nettype none
`include "dadu_cfg.svh"
module dadu_unit_checker (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic op_valid_i,
  input wire dadu_pkg::dadu_op_t op_i,
  input wire logic mode64_i,
  input wire logic user_or_super_i,
  input wire logic [4:0] dest_field_i,
  input wire logic [63:0] first_source_i,
  input wire logic [63:0] second_source_i,
  input wire logic rd_we_o,
  input wire logic [4:0] rd_addr_o,
  input wire logic [63:0] rd_data_o,
  input wire logic reserved_trap_o,
  input wire logic div_busy_o,
  input wire logic prod_valid_o,
  input wire logic [63:0] product_low_reg_o,
  input wire logic [63:0] product_high_reg_o
);
  // ====
  // take conditions, decoded once for all properties
  logic take, bad_mode, trap_op, take_add, take_dw, take_w;
  assign take = op_valid_i && (op_i != dadu_pkg::DADU_OP_NONE) && !div_busy_o;
  assign bad_mode = !mode64_i && user_or_super_i;
  assign trap_op = take && bad_mode && (op_i != dadu_pkg::DADU_OP_DIV);
  assign take_add = take && !bad_mode && (op_i == dadu_pkg::DADU_OP_ADDU);
  assign take_dw = take && !bad_mode && (op_i inside {dadu_pkg::DADU_OP_DWORD_SIGNED_DIVIDE,
      dadu_pkg::DADU_OP_DWORD_UNSIGNED_DIVIDE});
  assign take_w = take && (op_i == dadu_pkg::DADU_OP_DIV);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ====
  // divide phases: running, then poisoned product registers
  sequence s_run;
    (div_busy_o && !prod_valid_o)[*2];
  endsequence
  sequence s_poison;
    product_low_reg_o == `DADU_POISON && product_high_reg_o == `DADU_POISON;
  endsequence
  add_write_a: assert property (take_add |=> rd_we_o && rd_addr_o == $past(dest_field_i)
      && rd_data_o == $past(first_source_i) + $past(second_source_i))
    else $error("add result or destination wrong");
  trap_dword_a: assert property (trap_op |=> reserved_trap_o && !rd_we_o)
    else $error("missing reserved trap");
  trap_only_a: assert property (take && !trap_op |=> !reserved_trap_o)
    else $error("unexpected reserved trap");
  dword_latency_a: assert property (take_dw |-> ##1 s_run ##65 prod_valid_o && !div_busy_o)
    else $error("doubleword divide timing wrong");
  word_latency_a: assert property (take_w |-> ##35 prod_valid_o)
    else $error("word divide timing wrong");
  rise_cause_a: assert property ($rose(prod_valid_o) |-> $past(take_dw, 67) || $past(take_w, 35))
    else $error("products valid without a divide");
  poison_a: assert property (take_dw || take_w |-> ##2 s_poison)
    else $error("products not poisoned while running");
  stable_a: assert property (prod_valid_o && $past(prod_valid_o) |->
      $stable(product_low_reg_o) && $stable(product_high_reg_o))
    else $error("products changed while valid");
endmodule : dadu_unit_checker
bind dadu_unit dadu_unit_checker u_chk (.clk_i, .rst_b_i, .op_valid_i, .op_i, .mode64_i,
  .user_or_super_i, .dest_field_i, .first_source_i, .second_source_i, .rd_we_o, .rd_addr_o,
  .rd_data_o, .reserved_trap_o, .div_busy_o, .prod_valid_o, .product_low_reg_o,
  .product_high_reg_o);
`default_nettype wire

// ===== bench/dadu_gpr_model.sv
// register file model on the decode side of the unit
// assumes writes come as one-cycle pulses, read port is combinational
`default_nettype none
module dadu_gpr_model (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [4:0] waddr_i,
  input wire logic [63:0] wdata_i,
  input wire logic [4:0] raddr_i,
  output logic [63:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // storage; unwritten entries stay unknown so stray reads show up
  logic [63:0] regs [32];
  always @(posedge clk_i) begin
    if (we_i) begin
      regs[waddr_i] <= wdata_i;
    end
  end
  assign rdata_o = regs[raddr_i];
endmodule : dadu_gpr_model
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the add and divide unit
// assumes unit, checker and register file model compiled before it
`default_nettype none
`include "dadu_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_b_i, op_valid_i, mode64_i, user_or_super_i;
  logic rd_we_o, reserved_trap_o, div_busy_o, prod_valid_o;
  dadu_pkg::dadu_op_t op_i;
  logic [4:0] dest_field_i, rd_addr_o;
  logic [63:0] first_source_i, second_source_i, rd_data_o, gpr_q;
  logic [63:0] product_low_reg_o, product_high_reg_o;
  integer seed = 79;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  dadu_unit u_dadu_unit (.clk_i, .rst_b_i, .op_valid_i, .op_i, .mode64_i, .user_or_super_i,
    .dest_field_i, .first_source_i, .second_source_i, .rd_we_o, .rd_addr_o, .rd_data_o,
    .reserved_trap_o, .div_busy_o, .prod_valid_o, .product_low_reg_o, .product_high_reg_o);
  dadu_gpr_model u_dadu_gpr_model (.clk_i, .we_i(rd_we_o), .waddr_i(rd_addr_o),
    .wdata_i(rd_data_o), .raddr_i(dest_field_i), .rdata_o(gpr_q));
  // ====
  // clock and hang guard, run needs well under 10k cycles
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] want);
    n_checks++;
    if (seen !== want) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, want, seen);
    end
  endtask : chk
  // quotient low half, remainder high half
  function automatic logic [127:0] exp_div(input dadu_pkg::dadu_op_t op,
      input logic [63:0] a, input logic [63:0] b);
    logic signed [31:0] q, r;
    q = $signed(a[31:0]) / $signed(b[31:0]);
    r = $signed(a[31:0]) % $signed(b[31:0]);
    if (op == dadu_pkg::DADU_OP_DWORD_UNSIGNED_DIVIDE) return {a % b, a / b};
    if (op == dadu_pkg::DADU_OP_DWORD_SIGNED_DIVIDE) return {$signed(a) % $signed(b), $signed(a) / $signed(b)};
    return {{{32{r[31]}}, r}, {{32{q[31]}}, q}};
  endfunction : exp_div
  // ====
  // one operation; adds offered while busy must be ignored
  task automatic run(input dadu_pkg::dadu_op_t op, input logic m64, input logic uos,
      input logic [63:0] a, input logic [63:0] b);
    logic trap;
    int n;
    trap = !m64 && uos && op != dadu_pkg::DADU_OP_DIV;
    @(posedge clk_i);
    op_valid_i <= 1'b1;
    op_i <= op;
    mode64_i <= m64;
    user_or_super_i <= uos;
    first_source_i <= a;
    second_source_i <= b;
    dest_field_i <= a[4:0] | 5'h01;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    #1;
    chk("trap", reserved_trap_o, trap);
    if (trap) chk("idle", {rd_we_o, div_busy_o}, 2'h0);
    else if (op == dadu_pkg::DADU_OP_ADDU) begin
      chk("we", rd_we_o, 1'b1);
      chk("sum", rd_data_o, a + b);
      @(posedge clk_i);
      #1;
      chk("gpr", gpr_q, a + b);
    end else begin
      n = 1;
      while (prod_valid_o !== 1'b1 && n < 99) begin
        chk("run", {div_busy_o, rd_we_o, reserved_trap_o}, 3'h4);
        if (n == 2) chk("poison", product_high_reg_o, `DADU_POISON);
        @(posedge clk_i);
        op_valid_i <= n > 2 && n < 30;
        op_i <= dadu_pkg::DADU_OP_ADDU;
        #1;
        n++;
      end
      chk("latency", n - 1, (op == dadu_pkg::DADU_OP_DIV ? `DADU_STEPS_WORD : `DADU_STEPS_DWORD) + 2);
      if (b != 64'h0) chk("lo", product_low_reg_o, 64'(exp_div(op, a, b)));
      if (b != 64'h0) chk("hi", product_high_reg_o, 64'(exp_div(op, a, b) >> 64));
    end
  endtask : run
  initial begin
    logic [63:0] a, b;
    logic [31:0] r;
    rst_b_i = 1'b0;
    op_valid_i = 1'b0;
    op_i = dadu_pkg::DADU_OP_NONE;
    {mode64_i, user_or_super_i, dest_field_i} = 7'h40;
    {first_source_i, second_source_i} = 128'h0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    // corners: top carry, negative dividend, 32-bit user word divide, zero divisor
    run(dadu_pkg::DADU_OP_ADDU, 1'b1, 1'b0, 64'hFFFF_FFFF_FFFF_FFFF, 64'h2);
    run(dadu_pkg::DADU_OP_DWORD_SIGNED_DIVIDE, 1'b1, 1'b1, 64'hFFFF_FFFF_FFFF_FFF9, 64'h2);
    run(dadu_pkg::DADU_OP_DWORD_UNSIGNED_DIVIDE, 1'b1, 1'b0, 64'hFFFF_FFFF_FFFF_FFF9, 64'h2);
    run(dadu_pkg::DADU_OP_DIV, 1'b0, 1'b1, 64'hFFFF_FFFF_8000_0000, 64'h3);
    run(dadu_pkg::DADU_OP_DWORD_UNSIGNED_DIVIDE, 1'b1, 1'b0, 64'h5, 64'h0);
    for (int i = 0; i < 48; i++) begin
      r = $random(seed);
      a = {$random(seed), $random(seed)};
      b = {$random(seed), $random(seed)} >> r[7:2];
      // word operands sign-extended by the issuing side
      if (i % 4 == 3) a = {{32{a[31]}}, a[31:0]};
      if (i % 4 == 3) b = {{32{b[31]}}, b[31:0]};
      run(dadu_pkg::dadu_op_t'(3'(i % 4 + 1)), r[0], r[1], a, b);
    end
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
